// [hw/lsc_lane_config.sv]
// Notes on behaviour
// - tx enable bit 10, resets to one
// - powerdown pin or global bit kills tx
// - two-lane mode disables tx lanes 3,2
// - single-lane mode disables tx lanes 3,2,1
// - rx enable bit 2, resets to one
// - powerdown pin or global bit kills rx
// - lane modes disable rx lanes likewise
// - tx rate bits 9:8, 11 reserved
// - rx rate bits 1:0, 11 reserved
// - de-emphasis bits 7:4, sixteen steps
// - swing bits 14:12, eight rising steps
// - bit 15 of third swaps rx polarity
// - bit 14 of third swaps tx polarity
// - equalizer bits 11:8 of third, reset 0
// - reserved low byte resets to 0x0D
// - second register at 0x0007, reset 0xDC04
// - third register at 0x0008, reset 0x000D
// - swing field resets to 101
module lsc_lane_config
	import lsc_pkg::*;
#(
	parameter logic [4:0] PORT_ADDR = 5'h00
) (
	// clock and reset
	input  wire logic    i_sys_clk,
	input  wire logic    i_rstn,
	// management pins
	input  wire logic    i_mdc,
	input  wire logic    i_mdio,
	output logic         o_mdio,
	output logic         o_mdio_oe,
	// power and lane mode
	input  wire logic    i_channel_powerdown_n,
	input  wire logic    i_global_powerdown,
	input  wire logic    i_two_lane_mode,
	input  wire logic    i_single_lane_mode,
	// lane configuration
	output lsc_lane_cfg_t o_lane_cfg
);

	logic         mdc_s;
	logic         mdio_s;
	logic         pd_n_s;
	logic         mdc_d_q;
	logic         mdc_rise;
	lsc_mdio_st_t state_q;
	logic [4:0]   bit_cnt_q;
	logic [5:0]   pre_cnt_q;
	logic [12:0]  hdr_q;
	logic [12:0]  hdr_d;
	logic         hdr_match;
	logic         sel_q;
	logic [1:0]   op_q;
	logic [15:0]  shift_q;
	logic [15:0]  wdata;
	logic         frame_end;
	logic         wr_stb;
	logic [15:0]  addr_q;
	logic [15:0]  rd_q;
	logic [15:0]  rd_mux;
	logic         is_read;
	logic [15:0]  reg_two_q;
	logic [15:0]  reg_three_q;
	logic [3:0]   lane_allow;
	logic         pd_ok;

	// mdc, mdio and channel powerdown pins cross into the system clock through two flops
	lsc_sync #(
		.W(3)
	) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_async   ({i_mdc, i_mdio, i_channel_powerdown_n}),
		.o_sync    ({mdc_s, mdio_s, pd_n_s})
	);

	// management clock edge detect on the synchronised copy
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			mdc_d_q <= 1'b0;
		end else begin
			mdc_d_q <= mdc_s;
		end
	end

	assign mdc_rise = mdc_s & ~mdc_d_q;

	// header decode: start bit, opcode, port and device address
	assign hdr_d     = {hdr_q[11:0], mdio_s};
	assign hdr_match = (hdr_d[12] == 1'b0) && (hdr_d[9:5] == PORT_ADDR)
		&& (hdr_d[4:0] == LSC_DEV_ADDR);
	assign wdata     = {shift_q[14:0], mdio_s};
	assign frame_end = mdc_rise && (state_q == LSC_ST_DATA)
		&& (bit_cnt_q == LSC_DATA_BITS - 5'h01);
	assign wr_stb    = frame_end && sel_q && (op_q == LSC_OP_WRITE);
	assign is_read   = (op_q == LSC_OP_READ) || (op_q == LSC_OP_READ_INC);

	// frame sequencer, advanced on each management clock rising edge
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			state_q   <= LSC_ST_IDLE;
			bit_cnt_q <= 5'h00;
			pre_cnt_q <= 6'h00;
			hdr_q     <= 13'h0000;
			sel_q     <= 1'b0;
			op_q      <= LSC_OP_ADDR;
		end else if (mdc_rise) begin
			unique case (state_q)
				LSC_ST_IDLE: begin
					if (mdio_s) begin
						if (pre_cnt_q != LSC_PRE_BITS) begin
							pre_cnt_q <= pre_cnt_q + 6'h01;
						end
					end else begin
						// a zero after a full preamble is the first start bit
						if (pre_cnt_q == LSC_PRE_BITS) begin
							state_q   <= LSC_ST_HDR;
							bit_cnt_q <= 5'h00;
						end
						pre_cnt_q <= 6'h00;
					end
				end
				LSC_ST_HDR: begin
					hdr_q <= hdr_d;
					if (bit_cnt_q == LSC_HDR_BITS - 5'h01) begin
						state_q   <= LSC_ST_TA;
						bit_cnt_q <= 5'h00;
						sel_q     <= hdr_match;
						op_q      <= hdr_d[11:10];
					end else begin
						bit_cnt_q <= bit_cnt_q + 5'h01;
					end
				end
				LSC_ST_TA: begin
					if (bit_cnt_q == LSC_TA_BITS - 5'h01) begin
						state_q   <= LSC_ST_DATA;
						bit_cnt_q <= 5'h00;
					end else begin
						bit_cnt_q <= bit_cnt_q + 5'h01;
					end
				end
				LSC_ST_DATA: begin
					if (bit_cnt_q == LSC_DATA_BITS - 5'h01) begin
						state_q   <= LSC_ST_IDLE;
						bit_cnt_q <= 5'h00;
					end else begin
						bit_cnt_q <= bit_cnt_q + 5'h01;
					end
				end
			endcase
		end
	end

	// write data shifts in msb first during the data phase
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			shift_q <= 16'h0000;
		end else if (mdc_rise && (state_q == LSC_ST_DATA)) begin
			shift_q <= wdata;
		end
	end

	// address frames load the pointer; read-increment advances it
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			addr_q <= 16'h0000;
		end else if (frame_end && sel_q) begin
			if (op_q == LSC_OP_ADDR) begin
				addr_q <= wdata;
			end else if (op_q == LSC_OP_READ_INC) begin
				addr_q <= addr_q + 16'h0001;
			end
		end
	end

	// read mux; unmapped addresses read as zero
	always_comb begin
		rd_mux = LSC_UNMAPPED_DATA;
		if (addr_q == LSC_REG_TWO_ADDR) begin
			rd_mux = reg_two_q;
		end else if (addr_q == LSC_REG_THREE_ADDR) begin
			rd_mux = reg_three_q;
		end
	end

	// read drive: zero in second turnaround bit, then data msb first
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			rd_q      <= 16'h0000;
			o_mdio    <= 1'b1;
			o_mdio_oe <= 1'b0;
		end else if (mdc_rise && sel_q && is_read) begin
			if (state_q == LSC_ST_TA && bit_cnt_q == 5'h00) begin
				rd_q      <= rd_mux;
				o_mdio    <= 1'b0;
				o_mdio_oe <= 1'b1;
			end else if (state_q == LSC_ST_TA
				|| (state_q == LSC_ST_DATA && !frame_end)) begin
				o_mdio <= rd_q[15];
				rd_q   <= {rd_q[14:0], 1'b0};
			end else if (frame_end) begin
				o_mdio    <= 1'b1;
				o_mdio_oe <= 1'b0;
			end
		end
	end

	// second register: whole word written, reserved bits kept as written
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			reg_two_q <= LSC_REG_TWO_RST;
		end else if (wr_stb && addr_q == LSC_REG_TWO_ADDR) begin
			reg_two_q <= wdata;
		end
	end

	// third register: reserved low byte resets to its fixed pattern
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			reg_three_q <= LSC_REG_THREE_RST;
		end else if (wr_stb && addr_q == LSC_REG_THREE_ADDR) begin
			reg_three_q <= wdata;
		end
	end

	// per-lane permission from power state and lane mode
	assign pd_ok = pd_n_s & ~i_global_powerdown;

	for (genvar l = 0; l < LSC_LANES; l++) begin : g_lane
		if (l >= 2) begin : g_upper
			assign lane_allow[l] = pd_ok & ~i_two_lane_mode
				& ~i_single_lane_mode;
		end else if (l == 1) begin : g_one
			assign lane_allow[l] = pd_ok & ~i_single_lane_mode;
		end else begin : g_zero
			assign lane_allow[l] = pd_ok;
		end
	end

	// registered lane configuration outputs
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_lane_cfg <= '0;
		end else begin
			o_lane_cfg.tx_lane_enable   <= lane_allow & {LSC_LANES{reg_two_q[LSC_TX_EN_BIT]}};
			o_lane_cfg.rx_lane_enable   <= lane_allow & {LSC_LANES{reg_two_q[LSC_RX_EN_BIT]}};
			o_lane_cfg.tx_lane_rate_sel <= reg_two_q[LSC_TX_RATE_LSB +: 2];
			o_lane_cfg.tx_rate_rsvd     <= reg_two_q[LSC_TX_RATE_LSB +: 2] == LSC_RATE_RSVD;
			o_lane_cfg.rx_lane_rate_sel <= reg_two_q[LSC_RX_RATE_LSB +: 2];
			o_lane_cfg.rx_rate_rsvd     <= reg_two_q[LSC_RX_RATE_LSB +: 2] == LSC_RATE_RSVD;
			o_lane_cfg.deemphasis_sel   <= reg_two_q[LSC_DEEMPH_LSB +: 4];
			o_lane_cfg.output_swing_sel <= reg_two_q[LSC_SWING_LSB +: 3];
			o_lane_cfg.equalizer_sel    <= reg_three_q[LSC_EQ_LSB +: 4];
			o_lane_cfg.tx_polarity_swap <= reg_three_q[LSC_TX_POL_BIT];
			o_lane_cfg.rx_polarity_swap <= reg_three_q[LSC_RX_POL_BIT];
		end
	end

	// checks on enables, forcing, fields and register access
	property p_tx_enable;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(reg_two_q[LSC_TX_EN_BIT] && pd_ok && !i_two_lane_mode && !i_single_lane_mode)
		|=> o_lane_cfg.tx_lane_enable == 4'hF;
	endproperty
	a_tx_enable: assert property (p_tx_enable)
		else $error("tx lanes not enabled");

	property p_tx_powerdown;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(!pd_n_s || i_global_powerdown) |=> o_lane_cfg.tx_lane_enable == 4'h0;
	endproperty
	a_tx_powerdown: assert property (p_tx_powerdown)
		else $error("tx lane alive in powerdown");

	property p_tx_two_lane;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_two_lane_mode && pd_ok && reg_two_q[LSC_TX_EN_BIT] && !i_single_lane_mode)
		|=> o_lane_cfg.tx_lane_enable == 4'h3;
	endproperty
	a_tx_two_lane: assert property (p_tx_two_lane)
		else $error("two-lane tx enables wrong");

	property p_tx_single_lane;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_single_lane_mode && pd_ok && reg_two_q[LSC_TX_EN_BIT])
		|=> o_lane_cfg.tx_lane_enable == 4'h1;
	endproperty
	a_tx_single_lane: assert property (p_tx_single_lane)
		else $error("single-lane tx enables wrong");

	property p_rx_disable;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		!reg_two_q[LSC_RX_EN_BIT] |=> o_lane_cfg.rx_lane_enable == 4'h0;
	endproperty
	a_rx_disable: assert property (p_rx_disable)
		else $error("rx lane on with enable clear");

	property p_rx_powerdown;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(!pd_n_s || i_global_powerdown) |=> o_lane_cfg.rx_lane_enable == 4'h0;
	endproperty
	a_rx_powerdown: assert property (p_rx_powerdown)
		else $error("rx lane alive in powerdown");

	property p_rx_modes;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_two_lane_mode || i_single_lane_mode) |=>
		(o_lane_cfg.rx_lane_enable[3:2] == 2'h0)
		&& (!$past(i_single_lane_mode) || !o_lane_cfg.rx_lane_enable[1]);
	endproperty
	a_rx_modes: assert property (p_rx_modes)
		else $error("rx lanes on in reduced lane mode");

	property p_rates;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		1'b1 |=> o_lane_cfg.tx_lane_rate_sel == $past(reg_two_q[9:8])
		&& o_lane_cfg.rx_lane_rate_sel == $past(reg_two_q[1:0]);
	endproperty
	a_rates: assert property (p_rates)
		else $error("rate field not passed on");

	property p_reset_values;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		$rose(i_rstn) |-> reg_two_q == 16'hDC04 && reg_three_q == 16'h000D
		&& o_lane_cfg.output_swing_sel == 3'h0;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("register reset value wrong");

	property p_write_readback;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(wr_stb && addr_q == LSC_REG_THREE_ADDR) |=> reg_three_q == $past(wdata);
	endproperty
	a_write_readback: assert property (p_write_readback)
		else $error("written value not held");

	property p_turnaround;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		$rose(o_mdio_oe) |-> !o_mdio;
	endproperty
	a_turnaround: assert property (p_turnaround)
		else $error("turnaround bit not zero");

endmodule : lsc_lane_config

// [hw/lsc_pkg.sv]
package lsc_pkg;

	// management frame fields
	localparam logic [4:0]  LSC_DEV_ADDR     = 5'h1E;
	localparam logic [5:0]  LSC_PRE_BITS     = 6'h20;
	localparam logic [4:0]  LSC_HDR_BITS     = 5'h0D;
	localparam logic [4:0]  LSC_TA_BITS      = 5'h02;
	localparam logic [4:0]  LSC_DATA_BITS    = 5'h10;
	localparam logic [1:0]  LSC_OP_ADDR      = 2'h0;
	localparam logic [1:0]  LSC_OP_WRITE     = 2'h1;
	localparam logic [1:0]  LSC_OP_READ_INC  = 2'h2;
	localparam logic [1:0]  LSC_OP_READ      = 2'h3;

	// register addresses and reset values
	localparam logic [15:0] LSC_REG_TWO_ADDR   = 16'h0007;
	localparam logic [15:0] LSC_REG_THREE_ADDR = 16'h0008;
	localparam logic [15:0] LSC_REG_TWO_RST    = 16'hDC04;
	localparam logic [15:0] LSC_REG_THREE_RST  = 16'h000D;
	localparam logic [15:0] LSC_UNMAPPED_DATA  = 16'h0000;

	// field positions in the second register
	localparam int LSC_SWING_LSB   = 12;
	localparam int LSC_TX_EN_BIT   = 10;
	localparam int LSC_TX_RATE_LSB = 8;
	localparam int LSC_DEEMPH_LSB  = 4;
	localparam int LSC_RX_EN_BIT   = 2;
	localparam int LSC_RX_RATE_LSB = 0;

	// field positions in the third register
	localparam int LSC_RX_POL_BIT  = 15;
	localparam int LSC_TX_POL_BIT  = 14;
	localparam int LSC_EQ_LSB      = 8;

	// lane rate codes
	localparam logic [1:0]  LSC_RATE_FULL    = 2'h0;
	localparam logic [1:0]  LSC_RATE_HALF    = 2'h1;
	localparam logic [1:0]  LSC_RATE_QUARTER = 2'h2;
	localparam logic [1:0]  LSC_RATE_RSVD    = 2'h3;

	localparam int LSC_LANES = 4;

	// frame receiver states
	typedef enum logic [1:0] {
		LSC_ST_IDLE,
		LSC_ST_HDR,
		LSC_ST_TA,
		LSC_ST_DATA
	} lsc_mdio_st_t;

	// configuration handed to the lane analog
	typedef struct packed {
		logic [3:0] tx_lane_enable;
		logic [3:0] rx_lane_enable;
		logic [1:0] tx_lane_rate_sel;
		logic       tx_rate_rsvd;
		logic [1:0] rx_lane_rate_sel;
		logic       rx_rate_rsvd;
		logic [3:0] deemphasis_sel;
		logic [2:0] output_swing_sel;
		logic [3:0] equalizer_sel;
		logic       tx_polarity_swap;
		logic       rx_polarity_swap;
	} lsc_lane_cfg_t;

endpackage : lsc_pkg

// [hw/lsc_sync.sv]
module lsc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_rstn,
	// asynchronous levels in, synchronised levels out
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// two flops; the first is read by the second only
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule : lsc_sync

// [tb/lsc_mdio_host.sv]
module lsc_mdio_host
	import lsc_pkg::*;
#(
	parameter logic [4:0] PRTAD = 5'h00
) (
	// clock
	input  wire logic i_sys_clk,
	// resolved data line
	input  wire logic i_mdio,
	// management clock and host drive
	output logic      o_mdc,
	output logic      o_mdio,
	output logic      o_mdio_oe
);
	timeunit 1ns;
	timeprecision 1ns;

	// clock rests low and line is released between frames
	initial begin
		o_mdc     = 1'b0;
		o_mdio    = 1'b1;
		o_mdio_oe = 1'b0;
	end

	// one 65-bit frame, 4 clk low and 4 clk high per bit; the extra bit lets a read finish
	task automatic frame(input logic [4:0] dev, input logic [1:0] op,
		input logic [15:0] data, output logic [15:0] rd);
		logic [64:0] bits;
		logic [15:0] cap;
		bits = {32'hFFFFFFFF, 2'b00, op, PRTAD, dev, 2'b10, data, 1'b1};
		cap = 16'h0000;
		for (int i = 64; i >= 0; i--) begin
			@(posedge i_sys_clk);
			o_mdc     <= 1'b0;
			o_mdio    <= bits[i];
			o_mdio_oe <= !(op[1] && (i <= 18)); // let go from turnaround on reads
			repeat (4) @(posedge i_sys_clk);
			if (i >= 1) begin
				cap = {cap[14:0], i_mdio}; // trailing idle bit is not data
			end
			o_mdc <= 1'b1;
			repeat (3) @(posedge i_sys_clk);
		end
		// clock back to rest low, so a reset never finds it high
		@(posedge i_sys_clk);
		o_mdc     <= 1'b0;
		o_mdio_oe <= 1'b0;
		rd = cap;
	endtask : frame

	// address frame then write frame
	task automatic wr(input logic [15:0] addr, input logic [15:0] data);
		logic [15:0] d;
		frame(LSC_DEV_ADDR, LSC_OP_ADDR, addr, d);
		frame(LSC_DEV_ADDR, LSC_OP_WRITE, data, d);
	endtask : wr

	// address frame then read frame
	task automatic rd(input logic [15:0] addr, output logic [15:0] data);
		logic [15:0] d;
		frame(LSC_DEV_ADDR, LSC_OP_ADDR, addr, d);
		frame(LSC_DEV_ADDR, LSC_OP_READ, 16'h0000, data);
	endtask : rd

endmodule : lsc_mdio_host

// [tb/tb.sv]
module tb
	import lsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [15:0] two;
		logic [15:0] three;
		logic [3:0]  pins; // powerdown_n, global pd, two-lane, single-lane
		logic [7:0]  en;   // expected tx and rx lane enables
	} lsc_row_t;

	logic          i_sys_clk;
	logic          i_rstn;
	logic          i_channel_powerdown_n;
	logic          i_global_powerdown;
	logic          i_two_lane_mode;
	logic          i_single_lane_mode;
	wire logic     mdc;
	wire logic     host_mdio;
	wire logic     host_oe;
	wire logic     dev_mdio;
	wire logic     dev_oe;
	wire logic     mdio_line;
	lsc_lane_cfg_t lane_cfg;
	int            num_errors;
	int            total_checks;
	logic [15:0]   rd;

	lsc_row_t rows [6] = '{
		'{16'h5D35, 16'h8A0D, 4'h8, 8'hFF},
		'{16'h7AF6, 16'h4F0D, 4'hA, 8'h03},
		'{16'h0704, 16'hF3FF, 4'h9, 8'h11},
		'{16'hDC07, 16'h000D, 4'h0, 8'h00},
		'{16'hDC07, 16'h000D, 4'hC, 8'h00},
		'{16'h0000, 16'h0000, 4'h8, 8'h00}
	};

	// pulled-up shared data line
	assign mdio_line = dev_oe ? dev_mdio : (host_oe ? host_mdio : 1'b1);

	lsc_lane_config i_lsc_lane_config (
		.i_sys_clk            (i_sys_clk),
		.i_rstn               (i_rstn),
		.i_mdc                (mdc),
		.i_mdio               (mdio_line),
		.o_mdio               (dev_mdio),
		.o_mdio_oe            (dev_oe),
		.i_channel_powerdown_n(i_channel_powerdown_n),
		.i_global_powerdown   (i_global_powerdown),
		.i_two_lane_mode      (i_two_lane_mode),
		.i_single_lane_mode   (i_single_lane_mode),
		.o_lane_cfg           (lane_cfg)
	);

	lsc_mdio_host i_lsc_mdio_host (
		.i_sys_clk(i_sys_clk),
		.i_mdio   (mdio_line),
		.o_mdc    (mdc),
		.o_mdio   (host_mdio),
		.o_mdio_oe(host_oe)
	);

	// expected lane configuration from register words and pins
	function automatic lsc_lane_cfg_t exp_cfg(logic [15:0] two, logic [15:0] three, logic [3:0] p);
		logic [3:0]    allow;
		logic          on;
		lsc_lane_cfg_t c;
		allow = p[0] ? 4'h1 : (p[1] ? 4'h3 : 4'hF);
		on = p[3] & !p[2];
		c.tx_lane_enable   = (two[10] & on) ? allow : 4'h0;
		c.rx_lane_enable   = (two[2] & on) ? allow : 4'h0;
		c.tx_lane_rate_sel = two[9:8];
		c.tx_rate_rsvd     = (two[9:8] == 2'h3);
		c.rx_lane_rate_sel = two[1:0];
		c.rx_rate_rsvd     = (two[1:0] == 2'h3);
		c.deemphasis_sel   = two[7:4];
		c.output_swing_sel = two[14:12];
		c.equalizer_sel    = three[11:8];
		c.tx_polarity_swap = three[14];
		c.rx_polarity_swap = three[15];
		return c;
	endfunction : exp_cfg

	// register word comparison
	task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk16

	// lane configuration comparison
	task automatic chk_cfg(input lsc_lane_cfg_t exp);
		total_checks++;
		if (lane_cfg !== exp) begin
			num_errors++;
			$display("MISMATCH lane_cfg expected %h seen %h", exp, lane_cfg);
		end
	endtask : chk_cfg

	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	// free-running system clock
	initial begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge i_sys_clk);
		num_errors++;
		final_report();
	end

	// main sequence
	initial begin
		num_errors = 0;
		total_checks = 0;
		i_rstn = 1'b0;
		{i_channel_powerdown_n, i_global_powerdown, i_two_lane_mode, i_single_lane_mode} = 4'h8;
		repeat (16) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		foreach (rows[n]) begin
			{i_channel_powerdown_n, i_global_powerdown, i_two_lane_mode, i_single_lane_mode}
				<= rows[n].pins;
			i_lsc_mdio_host.wr(LSC_REG_TWO_ADDR, rows[n].two);
			i_lsc_mdio_host.wr(LSC_REG_THREE_ADDR, rows[n].three);
			i_lsc_mdio_host.frame(LSC_DEV_ADDR, LSC_OP_ADDR, LSC_REG_TWO_ADDR, rd);
			i_lsc_mdio_host.frame(LSC_DEV_ADDR, LSC_OP_READ_INC, 16'h0000, rd);
			chk16("reg_two", rows[n].two, rd);
			i_lsc_mdio_host.frame(LSC_DEV_ADDR, LSC_OP_READ, 16'h0000, rd);
			chk16("reg_three", rows[n].three, rd);
			chk_cfg(exp_cfg(rows[n].two, rows[n].three, rows[n].pins));
			chk16("lane_en", {8'h00, rows[n].en},
				{8'h00, lane_cfg.tx_lane_enable, lane_cfg.rx_lane_enable});
		end
		// mid-run reset restores both words
		i_rstn <= 1'b0;
		{i_channel_powerdown_n, i_global_powerdown, i_two_lane_mode, i_single_lane_mode} <= 4'h8;
		repeat (16) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		i_lsc_mdio_host.rd(16'h0007, rd);
		chk16("reset_two", 16'hDC04, rd);
		i_lsc_mdio_host.rd(16'h0008, rd);
		chk16("reset_three", 16'h000D, rd);
		chk_cfg(exp_cfg(16'hDC04, 16'h000D, 4'h8));
		// unmapped place reads zero and keeps nothing
		i_lsc_mdio_host.wr(16'h0009, 16'hFFFF);
		i_lsc_mdio_host.rd(16'h0009, rd);
		chk16("unmapped", 16'h0000, rd);
		// frame for another device space is ignored
		i_lsc_mdio_host.frame(5'h1D, LSC_OP_ADDR, 16'h0007, rd);
		i_lsc_mdio_host.frame(5'h1D, LSC_OP_WRITE, 16'h0000, rd);
		i_lsc_mdio_host.rd(16'h0007, rd);
		chk16("other_dev", 16'hDC04, rd);
		// equalizer change keeps reserved neighbours
		i_lsc_mdio_host.rd(16'h0008, rd);
		i_lsc_mdio_host.wr(16'h0008, {rd[15:12], 4'h5, rd[7:0]});
		i_lsc_mdio_host.rd(16'h0008, rd);
		chk16("eq_rmw", 16'h050D, rd);
		chk_cfg(exp_cfg(16'hDC04, 16'h050D, 4'h8));
		final_report();
	end

endmodule : tb
